/* File: src/fcso_pkg.sv */
// package for flash clock ratio and option register block
package fcso_pkg;
   // register byte addresses
   localparam logic [11:0] FCSO_CLKDIV_OFS = 12'h000;
   localparam logic [11:0] FCSO_OPTS_OFS = 12'h004;
   localparam logic [11:0] FCSO_KEYCTL_OFS = 12'h008;
   localparam logic [11:0] FCSO_KEYDAT_OFS = 12'h00C;
   localparam logic [11:0] FCSO_STAT_OFS = 12'h010;
   // clock ratio register fields
   localparam int FCSO_LOADED_BIT = 7;
   localparam int FCSO_PRESCALE_BIT = 6;
   localparam int FCSO_RATIO_MSB = 5;
   localparam logic [6:0] FCSO_CLKDIV_RST = 7'h00;
   localparam int FCSO_PRESCALE_DIV = 8;
   // option register fields
   localparam int FCSO_UNLOCK_ALLOW_BIT = 7;
   localparam int FCSO_REMAP_OFF_BIT = 6;
   localparam logic [7:0] FCSO_OPT_MASK = 8'hC3;
   localparam logic [1:0] FCSO_UNSECURED_CODE = 2'h2;
   // key handling
   localparam int FCSO_KEY_BYTES = 8;
   localparam int FCSO_KEY_MODE_BIT = 0;
   // status register fields
   localparam int FCSO_STAT_SECURE_BIT = 0;
   localparam int FCSO_STAT_PGM_OK_BIT = 1;
   localparam int FCSO_STAT_KEYCNT_LSB = 4;
   // timing limit on one flash timing clock cycle
   localparam real FCSO_PULSE_MAX_US = 6.7;
endpackage : fcso_pkg

/* File: src/fcso_ctrl.sv */
// flash clock ratio, option register and backdoor unlock logic
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - byte registers; option copies loaded at reset
// - eight-byte stored unlock key kept
// - loaded flag read-only; low bits write-once
// - loaded flag cleared by reset, set first write
// - erase/program blocked until flag set
// - prescale bit selects bus or bus/8
// - timing clock divides by ratio plus one
// - timing pulse is one bus clock, once per timing clock cycle
// - option register loaded only during reset
// - unlock allow zero disables backdoor unlock
// - key writes only from secured firmware
// - matching eight ordered bytes unsecure until reset
// - remap-off bit disables vector redirection
// - code 1:0 unsecured, others secure
// - secure denies memory to unsecured sources
// - key match or blank check sets 1:0
// - key mode steers key writes vs commands
module fcso_ctrl import fcso_pkg::*; #(
   parameter int KEY_BYTES = FCSO_KEY_BYTES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // nonvolatile contents
   input wire logic [7:0] stored_option_byte,
   input wire logic [7:0] stored_protect_byte,
   input wire logic [63:0] stored_unlock_key,
   // system side
   input wire logic access_from_secure,
   input wire logic blank_check_pass,
   input wire logic mem_access_req,
   input wire logic mem_access_unsecured,
   // outputs
   output logic flash_timing_clock,
   output logic timing_pulse,
   output logic pgm_erase_enable,
   output logic [7:0] working_protect_reg,
   output logic vector_remap_off,
   output logic secure_state,
   output logic mem_access_grant,
   output logic flash_cmd_start
);
   logic [6:0] clkdiv_q, clkdiv_d;
   logic ratio_loaded_flag_q;
   logic [7:0] opts_q;
   logic [1:0] lock_state_code_q, lock_state_code_d;
   logic in_reset_q;
   logic key_write_mode_q;
   logic [3:0] key_idx_q;
   logic key_ok_q;
   logic [2:0] pre_cnt_q;
   logic [5:0] div_cnt_q;
   logic tclk_q, pulse_q, cmd_q;
   logic [9:0] gap_q;
   logic gap_seen_q;

   // bus decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_div = paddr == FCSO_CLKDIV_OFS;
   wire hit_opt = paddr == FCSO_OPTS_OFS;
   wire hit_kctl = paddr == FCSO_KEYCTL_OFS;
   wire hit_kdat = paddr == FCSO_KEYDAT_OFS;
   wire hit_stat = paddr == FCSO_STAT_OFS;
   wire mapped = hit_div | hit_opt | hit_kctl | hit_kdat | hit_stat;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   wire [7:0] clkdiv_rd = {ratio_loaded_flag_q, clkdiv_q};
   wire [7:0] opt_rd = {opts_q[7:6], 4'h0, lock_state_code_q};
   wire [7:0] stat_rd = {key_idx_q, 2'h0, ratio_loaded_flag_q, secure_state};
   wire [7:0] rd_byte = hit_div ? clkdiv_rd :
                        hit_opt ? opt_rd :
                        hit_kctl ? {7'h00, key_write_mode_q} :
                        hit_stat ? stat_rd : 8'h00;

   wire div_wr = wr & hit_div & ~ratio_loaded_flag_q;
   assign clkdiv_d = div_wr ? pwdata[6:0] : clkdiv_q;

   // key stream
   wire kdat_wr = wr & hit_kdat;
   wire kctl_wr = wr & hit_kctl;
   wire key_wr = kdat_wr & key_write_mode_q & access_from_secure;
   wire [7:0] key_exp = stored_unlock_key[8*key_idx_q[2:0] +: 8];
   wire byte_ok = pwdata[7:0] == key_exp;
   wire key_done = key_idx_q == 4'(KEY_BYTES);
   // all eight matched on leaving key mode
   wire unlock = kctl_wr & key_write_mode_q & ~pwdata[FCSO_KEY_MODE_BIT] & key_done
                 & key_ok_q & opts_q[FCSO_UNLOCK_ALLOW_BIT];
   assign lock_state_code_d = (unlock | blank_check_pass) ? FCSO_UNSECURED_CODE
                                                          : lock_state_code_q;

   // loaded flag set on first write
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ratio_loaded_flag_q <= 1'b0;
         clkdiv_q <= FCSO_CLKDIV_RST;
      end else begin
         clkdiv_q <= clkdiv_d;
         if (wr & hit_div) begin
            ratio_loaded_flag_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      in_reset_q <= ~nrst;
      if (!nrst || in_reset_q) begin
         opts_q <= stored_option_byte & FCSO_OPT_MASK;
         working_protect_reg <= stored_protect_byte;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst || in_reset_q) begin
         lock_state_code_q <= stored_option_byte[1:0];
      end else begin
         lock_state_code_q <= lock_state_code_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         key_write_mode_q <= 1'b0;
         key_idx_q <= 4'h0;
         key_ok_q <= 1'b1;
         cmd_q <= 1'b0;
      end else begin
         cmd_q <= kdat_wr & ~key_write_mode_q & ratio_loaded_flag_q;
         if (kctl_wr) begin
            key_write_mode_q <= pwdata[FCSO_KEY_MODE_BIT];
            key_idx_q <= 4'h0;
            key_ok_q <= 1'b1;
         end else if (key_wr) begin
            if (key_done) begin
               key_ok_q <= 1'b0;
            end else begin
               key_idx_q <= key_idx_q + 4'h1;
               key_ok_q <= key_ok_q & byte_ok;
            end
         end
      end
   end

   wire pre_tick = ~clkdiv_q[FCSO_PRESCALE_BIT] |
                   (pre_cnt_q == 3'(FCSO_PRESCALE_DIV - 1));
   wire div_wrap = pre_tick & (div_cnt_q == clkdiv_q[FCSO_RATIO_MSB:0]);
   // timing clock high for first half
   wire tclk_high = div_cnt_q <= {1'b0, clkdiv_q[FCSO_RATIO_MSB:1]};
   always_ff @(posedge sys_clk) begin
      if (!nrst || !ratio_loaded_flag_q) begin
         pre_cnt_q <= 3'h0;
         div_cnt_q <= 6'h00;
         tclk_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
         pulse_q <= div_wrap;
         tclk_q <= tclk_high;
         if (div_wrap) begin
            div_cnt_q <= 6'h00;
         end else if (pre_tick) begin
            div_cnt_q <= div_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end

   assign timing_pulse = pulse_q;
   assign flash_timing_clock = tclk_q;
   assign pgm_erase_enable = ratio_loaded_flag_q;
   assign flash_cmd_start = cmd_q;
   assign vector_remap_off = opts_q[FCSO_REMAP_OFF_BIT];
   assign secure_state = lock_state_code_q != FCSO_UNSECURED_CODE;
   assign mem_access_grant = mem_access_req & ~(secure_state & mem_access_unsecured);

   // assertions
   // helper: cycles since last pulse
   wire [9:0] ratio_p1 = {4'h0, clkdiv_q[FCSO_RATIO_MSB:0]} + 10'h001;
   wire [9:0] gap_exp = clkdiv_q[FCSO_PRESCALE_BIT] ? {ratio_p1[6:0], 3'h0} : ratio_p1;
   always_ff @(posedge sys_clk) begin
      if (!nrst || !ratio_loaded_flag_q) begin
         gap_q <= 10'h000;
         gap_seen_q <= 1'b0;
      end else if (pulse_q) begin
         gap_q <= 10'h001;
         gap_seen_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 10'h001;
      end
   end
   property p_loaded_sticky;
      @(posedge sys_clk) disable iff (!nrst) ratio_loaded_flag_q |=> ratio_loaded_flag_q;
   endproperty
   a_loaded_sticky: assert property (p_loaded_sticky) else $error("loaded flag fell");
   property p_first_write;
      @(posedge sys_clk) disable iff (!nrst)
         (wr & hit_div & ~ratio_loaded_flag_q) |=> ratio_loaded_flag_q && clkdiv_q == $past(pwdata[6:0]);
   endproperty
   a_first_write: assert property (p_first_write) else $error("first ratio write lost");
   property p_write_once;
      @(posedge sys_clk) disable iff (!nrst) ratio_loaded_flag_q |=> $stable(clkdiv_q);
   endproperty
   a_write_once: assert property (p_write_once) else $error("ratio changed twice");
   property p_no_pgm;
      @(posedge sys_clk) disable iff (!nrst) ~ratio_loaded_flag_q |-> ~pgm_erase_enable && ~flash_cmd_start;
   endproperty
   a_no_pgm: assert property (p_no_pgm) else $error("program allowed early");
   property p_unsec;
      @(posedge sys_clk) disable iff (!nrst)
         ((unlock | blank_check_pass) && !in_reset_q) |=> ~secure_state;
   endproperty
   a_unsec: assert property (p_unsec) else $error("unlock ignored");
   property p_backdoor_unlock_allow;
      @(posedge sys_clk) disable iff (!nrst)
         (!opts_q[FCSO_UNLOCK_ALLOW_BIT] && secure_state && !blank_check_pass && !in_reset_q)
            |=> secure_state;
   endproperty
   a_backdoor_unlock_allow: assert property (p_backdoor_unlock_allow) else $error("unlock without allow");
   property p_deny;
      @(posedge sys_clk) disable iff (!nrst)
         (secure_state & mem_access_unsecured) |-> ~mem_access_grant;
   endproperty
   a_deny: assert property (p_deny) else $error("secure access leaked");
   property p_opt_stable;
      @(posedge sys_clk) disable iff (!nrst || in_reset_q) $stable(opts_q);
   endproperty
   a_opt_stable: assert property (p_opt_stable) else $error("options changed");
   property p_pulse_gap;
      @(posedge sys_clk) disable iff (!nrst)
         (pulse_q && !clkdiv_q[FCSO_PRESCALE_BIT] && clkdiv_q[5:0] == 6'h01) |=> !pulse_q ##1 pulse_q;
   endproperty
   a_pulse_gap: assert property (p_pulse_gap) else $error("pulse period wrong");
   c_unlock: cover property (@(posedge sys_clk) unlock);
   c_loaded: cover property (@(posedge sys_clk) $rose(ratio_loaded_flag_q));
   property p_loaded_clear;
      @(posedge sys_clk) disable iff (!nrst)
         in_reset_q |-> !ratio_loaded_flag_q && clkdiv_q == FCSO_CLKDIV_RST;
   endproperty
   a_loaded_clear: assert property (p_loaded_clear) else $error("loaded flag not cleared");
   property p_cmd_start;
      @(posedge sys_clk) disable iff (!nrst)
         (kdat_wr && !key_write_mode_q && ratio_loaded_flag_q) |=> flash_cmd_start;
   endproperty
   a_cmd_start: assert property (p_cmd_start) else $error("command not started");
   property p_key_no_cmd;
      @(posedge sys_clk) disable iff (!nrst) (kdat_wr && key_write_mode_q) |=> !flash_cmd_start;
   endproperty
   a_key_no_cmd: assert property (p_key_no_cmd) else $error("key write started command");
   property p_pulse_period;
      @(posedge sys_clk) disable iff (!nrst) (pulse_q && gap_seen_q) |-> gap_q == gap_exp;
   endproperty
   a_pulse_period: assert property (p_pulse_period) else $error("pulse period wrong");
   property p_tclk_rise;
      @(posedge sys_clk) disable iff (!nrst)
         ($rose(flash_timing_clock) && gap_seen_q) |-> $past(timing_pulse);
   endproperty
   a_tclk_rise: assert property (p_tclk_rise) else $error("timing clock off pulse");
   property p_protect;
      @(posedge sys_clk) disable iff (!nrst) !in_reset_q |=> $stable(working_protect_reg);
   endproperty
   a_protect: assert property (p_protect) else $error("protect copy changed");
   c_pulse: cover property (@(posedge sys_clk) timing_pulse);
   c_cmd: cover property (@(posedge sys_clk) flash_cmd_start);
   c_blank: cover property (@(posedge sys_clk) blank_check_pass && secure_state);
endmodule : fcso_ctrl
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the flash clock ratio and option block
`timescale 1ns/1ps
`default_nettype none
module testbench import fcso_pkg::*;;
   logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] opt, prot, wprot, eo;
   logic [63:0] key;
   logic from_sec, blank, mreq, munsec, tclk, tl, tpulse, pe_en, remap, sec, grant, cmd;
   int errors, comparisons, cmds, c0, n, r, p, rises;
   fcso_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stored_option_byte(opt), .stored_protect_byte(prot),
      .stored_unlock_key(key), .access_from_secure(from_sec), .blank_check_pass(blank),
      .mem_access_req(mreq), .mem_access_unsecured(munsec), .flash_timing_clock(tclk),
      .timing_pulse(tpulse), .pgm_erase_enable(pe_en), .working_protect_reg(wprot),
      .vector_remap_off(remap), .secure_state(sec), .mem_access_grant(grant),
      .flash_cmd_start(cmd));
   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (cmd === 1'h1) cmds++;
   task automatic end_of_test();
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (k >= 20) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic rst();
      nrst <= 1'h0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'h1;
      @(posedge sys_clk);
   endtask : rst
   // key entry, byte bad flipped
   task automatic unlock(input int bad);
      apb(1'h1, FCSO_KEYCTL_OFS, 32'h1);
      for (int i = 0; i < 8; i++)
         apb(1'h1, FCSO_KEYDAT_OFS, {24'h0, key[8*i+:8] ^ ((i == bad) ? 8'h1 : 8'h0)});
      apb(1'h1, FCSO_KEYCTL_OFS, 32'h0);
      repeat (2) @(posedge sys_clk);
   endtask : unlock
   initial begin
      #400000;
      errors++;
      end_of_test();
   end
   initial begin
      {nrst, psel, penable, pwrite, blank, mreq, munsec, from_sec} = 8'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      errors = 0;
      comparisons = 0;
      cmds = 0;
      void'($urandom(62062));
      key = {$urandom, $urandom};
      prot = 8'($urandom);
      opt = 8'h0;
      for (int c = 0; c < 4; c++) begin
         eo = 8'($urandom);
         eo[1:0] = c[1:0];
         opt <= eo;
         eo = eo & 8'hC3;
         rst();
         chk(sec, c != 2);
         chk(remap, opt[6]);
         chk(wprot, prot);
         apb(1'h0, FCSO_OPTS_OFS, 32'h0);
         chk(rd, eo);
         opt <= ~opt;
         apb(1'h0, FCSO_OPTS_OFS, 32'h0);
         chk(rd, eo);
      end
      for (p = 0; p < 2; p++) begin
         rst();
         chk(pe_en, 0);
         c0 = cmds;
         apb(1'h1, FCSO_KEYDAT_OFS, 32'h5);
         r = p ? 15 + $urandom_range(4) : 1 + $urandom_range(4);
         apb(1'h1, FCSO_CLKDIV_OFS, {25'($urandom), p[0], r[5:0]});
         apb(1'h1, FCSO_CLKDIV_OFS, 32'h7F);
         apb(1'h0, FCSO_CLKDIV_OFS, 32'h0);
         chk(rd, 32'h80 | (p << 6) | r);
         chk(pe_en, 1);
         apb(1'h1, FCSO_KEYDAT_OFS, 32'h5);
         repeat (2) @(posedge sys_clk);
         chk(cmds - c0, 1);
         n = 0;
         while (tpulse !== 1'h1 && n < 500) begin
            @(posedge sys_clk);
            n++;
         end
         tl = tclk;
         rises = 0;
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
            if (tclk === 1'h1 && tl === 1'h0) rises++;
            tl = tclk;
         end while (tpulse !== 1'h1 && n < 500);
         chk(n, (r + 1) * (p ? 8 : 1));
         chk(rises, 1);
      end
      apb(1'h0, 12'h014, 32'h0);
      chk(err, 1);
      chk(rd, 0);
      opt <= 8'h80;
      rst();
      mreq <= 1'h1;
      munsec <= 1'h1;
      @(posedge sys_clk);
      chk(grant, 0);
      unlock(9);
      chk(sec, 1);
      from_sec <= 1'h1;
      unlock($urandom_range(7));
      chk(sec, 1);
      unlock(9);
      chk(sec, 0);
      chk(grant, 1);
      rst();
      chk(sec, 1);
      opt <= 8'h00;
      rst();
      unlock(9);
      chk(sec, 1);
      blank <= 1'h1;
      @(posedge sys_clk);
      blank <= 1'h0;
      repeat (2) @(posedge sys_clk);
      chk(sec, 0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
